// *** core/cple_pkg.sv ***
// Constants and state types shared by both ends of the channel power-down
// and extra-lane control link. Assumes one 25 MHz clock feeds both ends.
//
// Behaviour
// - B power-down also downs bound digital channels
// - A power-down also downs bound digital channels
// - Host clears transmit enable before power-down changes
// - Both channels down goes through global mode
// - Both down: whole link, PLL, multiframe off
// - Single channel down keeps link A running
// - Host sets calibration offset one when needed
// - Extra bits 7..1 enable lane clocks 1..7
// - Serializer bit: clocks only, or serializers too
// - Host changes extra lanes only while disabled
// - Extra lanes follow current mode and pattern
// - Extra-only lanes send ramp for pattern 0/5
// - Extra lanes never override link power-down
// - Serializer n needs all lower lanes enabled
// - Status shows link up and PLL lock
`default_nettype none

package cple_pkg;

    // ************************************************************
    // Device register map
    // ************************************************************
    localparam int CPLE_AW = 12;
    localparam logic [11:0] CPLE_ADDR_OPMODE = 12'h002;
    localparam logic [11:0] CPLE_ADDR_CALCFG = 12'h061;
    localparam logic [11:0] CPLE_ADDR_LINKCTL = 12'h200;
    localparam logic [11:0] CPLE_ADDR_STATUS = 12'h208;
    localparam logic [11:0] CPLE_ADDR_PD = 12'h209;
    localparam logic [11:0] CPLE_ADDR_EXTRA = 12'h20A;

    // ************************************************************
    // Field positions and codes
    // ************************************************************
    localparam int CPLE_PD_A_BIT = 0;
    localparam int CPLE_PD_B_BIT = 1;
    localparam int CPLE_EXTRA_SER_BIT = 0;
    localparam int CPLE_LINK_EN_BIT = 0;
    localparam int CPLE_GPD_BIT = 0;
    localparam int CPLE_CAL_OFS_BIT = 0;
    localparam int CPLE_CAL_FG_BIT = 1;
    localparam int CPLE_ST_PLL_BIT = 2;
    localparam int CPLE_ST_LINK_BIT = 6;
    localparam logic [3:0] CPLE_PAT_NONE = 4'h0;
    localparam logic [3:0] CPLE_PAT_RAMP = 4'h4;
    localparam logic [3:0] CPLE_PAT_ALT = 4'h5;
    localparam int CPLE_LANES = 8;
    localparam int CPLE_DIGS = 4;

    // ************************************************************
    // Host command port map
    // ************************************************************
    localparam logic [3:0] CPLE_H_CTRL = 4'h0;
    localparam logic [3:0] CPLE_H_PDREQ = 4'h1;
    localparam logic [3:0] CPLE_H_EXTRA = 4'h2;
    localparam logic [3:0] CPLE_H_STATUS = 4'h3;
    localparam logic [3:0] CPLE_H_GO = 4'h4;
    localparam int CPLE_HC_LINK_BIT = 0;
    localparam int CPLE_HC_FG_BIT = 1;

    typedef logic [7:0][3:0] cple_pat_t;

    typedef struct packed {
        logic [1:0] pd;
        logic [7:0] extra;
        logic link_en;
        logic gpd;
        logic cal_ofs;
        logic cal_fg;
        logic [7:0] rdata;
        logic [7:0] clk_en;
        logic [7:0] ser_en;
        cple_pat_t pat;
        logic pd_a;
        logic pd_b;
        logic [3:0] dig_pd;
        logic pll_en;
        logic mf_en;
        logic link_up;
        logic [4:0] link_mode_select;
    } cple_dev_st_t;

    localparam cple_dev_st_t CPLE_DEV_RST = '0;

    typedef enum logic [8:0] {
        CPLE_S_IDLE = 9'h001,
        CPLE_S_DIS = 9'h002,
        CPLE_S_PD = 9'h004,
        CPLE_S_MODE = 9'h008,
        CPLE_S_EXTRA = 9'h010,
        CPLE_S_CAL = 9'h020,
        CPLE_S_EN = 9'h040,
        CPLE_S_RDST = 9'h080,
        CPLE_S_CAPT = 9'h100
    } cple_state_t;

    typedef struct packed {
        cple_state_t state;
        logic [7:0] ctrl;
        logic [1:0] pdreq;
        logic [7:0] extra;
        logic [7:0] dev_status;
        logic [7:0] rdata;
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cple_host_st_t;

    localparam cple_host_st_t CPLE_HOST_RST = '{state: CPLE_S_IDLE, default: '0};

endpackage

`default_nettype wire

// *** core/cple_link_if.sv ***
// Register link between the controller and the power/lane control block.
// Assumes both ends share i_clk; the controller is the only master.
`timescale 1ns/100ps
`default_nettype none

interface cple_link_if;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;

    modport dev (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

`default_nettype wire

// *** core/cple_lane_gate.sv ***
// Per-lane clock, serializer and pattern decisions for link A.
// Purely combinational; the caller registers every result.
`timescale 1ns/100ps
`default_nettype none

module cple_lane_gate
    import cple_pkg::*;
(
    input wire logic i_link_on,
    input wire logic i_tx_en,
    input wire logic [7:0] i_mode_mask,
    input wire logic [7:0] i_extra,
    input wire logic [3:0] i_pattern,
    output logic [7:0] o_clk_en,
    output logic [7:0] o_ser_en,
    output cple_pat_t o_pat
);
    logic [8:0] lower_ok;
    logic [7:0] want_ser;
    logic [7:0] extra_lane;
    logic extra_ser;

    // Bit 0 is the serializer mode, so lane 0 is only ever a mode lane
    assign extra_lane = {i_extra[7:1], 1'b0};
    assign extra_ser = i_extra[CPLE_EXTRA_SER_BIT];
    assign lower_ok[0] = 1'b1;

    genvar n;
    generate
        for (n = 0; n < CPLE_LANES; n++) begin : g_lane
            logic req;
            logic extra_only;
            // A downed link keeps every lane dark
            assign req = i_link_on & (i_mode_mask[n] | extra_lane[n]);
            assign o_clk_en[n] = req;
            assign want_ser[n] = req & (i_mode_mask[n] | extra_ser);
            // The serializer clock is chained lane to lane
            assign lower_ok[n + 1] = lower_ok[n] & want_ser[n];
            assign o_ser_en[n] = i_tx_en & want_ser[n] & lower_ok[n];
            assign extra_only = extra_lane[n] & ~i_mode_mask[n];
            always_comb begin
                if (extra_only &&
                    (i_pattern == CPLE_PAT_NONE || i_pattern == CPLE_PAT_ALT)) begin
                    o_pat[n] = CPLE_PAT_RAMP;
                end else begin
                    o_pat[n] = i_pattern;
                end
            end
        end
    endgenerate
endmodule // cple_lane_gate

`default_nettype wire

// *** core/cple_dev.sv ***
// Device end: channel power-down and link A extra lane control.
// Registers sit behind the link interface; mode lane mask, pattern
// select, channel binding and PLL lock come from the link subsystem.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module cple_dev
    import cple_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    cple_link_if.dev bus,
    input wire logic [4:0] i_link_mode_select,
    input wire logic [3:0] i_link_test_pattern_select,
    input wire logic [7:0] i_mode_lane_mask,
    input wire logic [3:0] i_digital_channel_binding,
    input wire logic i_pll_locked,
    input wire logic i_link_sync,
    output logic o_power_down_a_converter,
    output logic o_power_down_b_converter,
    output logic [3:0] o_dig_pd,
    output logic o_pll_en,
    output logic o_mfclk_en,
    output logic o_link_transmit_enable,
    output logic [4:0] o_lane_mode_select,
    output logic [7:0] o_lane_clk_en,
    output logic [7:0] o_ser_en,
    output cple_pat_t o_lane_pattern,
    output logic o_cal_offset_setting,
    output logic o_foreground_cal,
    output logic o_link_up,
    output logic o_pll_locked
);
    import cple_pkg::*;

    cple_dev_st_t st_reg;
    cple_dev_st_t st_next;

    logic pd_a_eff;
    logic pd_b_eff;
    logic sub_down;
    logic [7:0] gate_clk;
    logic [7:0] gate_ser;
    cple_pat_t gate_pat;
    logic [7:0] status_byte;
    logic [3:0] dig_pd_want;

    // ************************************************************
    // Power-down decode
    // ************************************************************
    // The global mode bit is the legal way to down both channels; the
    // same effect is kept if software sets both bits anyway.
    assign pd_a_eff = st_reg.pd[CPLE_PD_A_BIT] | st_reg.gpd;
    assign pd_b_eff = st_reg.pd[CPLE_PD_B_BIT] | st_reg.gpd;
    // Only both channels down takes the link away; one alone leaves
    // link A alive with the other slots undefined.
    assign sub_down = pd_a_eff & pd_b_eff;

    // ************************************************************
    // Digital channel binding
    // ************************************************************
    // Each digital channel follows the converter it is bound to
    genvar d;
    generate
        for (d = 0; d < CPLE_DIGS; d++) begin : g_dig
            assign dig_pd_want[d] = i_digital_channel_binding[d] ?
                                    pd_b_eff : pd_a_eff;
        end
    endgenerate

    // ************************************************************
    // Lane gating
    // ************************************************************
    cple_lane_gate u_gate (
        .i_link_on(~sub_down),
        .i_tx_en(st_reg.link_en),
        .i_mode_mask(i_mode_lane_mask),
        .i_extra(st_reg.extra),
        .i_pattern(i_link_test_pattern_select),
        .o_clk_en(gate_clk),
        .o_ser_en(gate_ser),
        .o_pat(gate_pat)
    );

    // ************************************************************
    // Status byte
    // ************************************************************
    always_comb begin
        // Reserved bits read as zero
        status_byte = 8'h00;
        status_byte[CPLE_ST_LINK_BIT] = st_reg.link_up;
        status_byte[CPLE_ST_PLL_BIT] = st_reg.pll_en & i_pll_locked;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        st_next.rdata = 8'h00;

        // ************************************************************
        // Register writes
        // ************************************************************
        if (bus.wr) begin
            case (bus.addr)
                CPLE_ADDR_PD: begin
                    // Upper bits are not stored
                    st_next.pd = bus.wdata[1:0];
                end
                CPLE_ADDR_EXTRA: begin
                    st_next.extra = bus.wdata;
                end
                CPLE_ADDR_LINKCTL: begin
                    st_next.link_en = bus.wdata[CPLE_LINK_EN_BIT];
                end
                CPLE_ADDR_OPMODE: begin
                    st_next.gpd = bus.wdata[CPLE_GPD_BIT];
                end
                CPLE_ADDR_CALCFG: begin
                    st_next.cal_ofs = bus.wdata[CPLE_CAL_OFS_BIT];
                    st_next.cal_fg = bus.wdata[CPLE_CAL_FG_BIT];
                end
                default: begin
                end
            endcase
        end

        // ************************************************************
        // Register reads
        // ************************************************************
        // Unmapped addresses read as zero
        if (bus.rd) begin
            case (bus.addr)
                CPLE_ADDR_PD: begin
                    st_next.rdata = {6'h00, st_reg.pd};
                end
                CPLE_ADDR_EXTRA: begin
                    st_next.rdata = st_reg.extra;
                end
                CPLE_ADDR_LINKCTL: begin
                    st_next.rdata[CPLE_LINK_EN_BIT] = st_reg.link_en;
                end
                CPLE_ADDR_OPMODE: begin
                    st_next.rdata[CPLE_GPD_BIT] = st_reg.gpd;
                end
                CPLE_ADDR_CALCFG: begin
                    st_next.rdata[CPLE_CAL_OFS_BIT] = st_reg.cal_ofs;
                    st_next.rdata[CPLE_CAL_FG_BIT] = st_reg.cal_fg;
                end
                CPLE_ADDR_STATUS: begin
                    st_next.rdata = status_byte;
                end
                default: begin
                end
            endcase
        end

        // ************************************************************
        // Derived outputs
        // ************************************************************
        // Outputs follow the stored settings one cycle later; the host
        // only changes them with the link disabled, so the lag is safe.
        st_next.pd_a = pd_a_eff;
        st_next.pd_b = pd_b_eff;
        st_next.dig_pd = dig_pd_want;
        st_next.pll_en = ~sub_down;
        st_next.mf_en = ~sub_down;
        st_next.clk_en = gate_clk;
        st_next.ser_en = gate_ser;
        st_next.pat = gate_pat;
        st_next.link_mode_select = i_link_mode_select;
        st_next.link_up = st_reg.link_en & ~sub_down & i_pll_locked & i_link_sync;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= CPLE_DEV_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign bus.rdata = st_reg.rdata;
    assign o_power_down_a_converter = st_reg.pd_a;
    assign o_power_down_b_converter = st_reg.pd_b;
    assign o_dig_pd = st_reg.dig_pd;
    assign o_pll_en = st_reg.pll_en;
    assign o_mfclk_en = st_reg.mf_en;
    assign o_link_transmit_enable = st_reg.link_en;
    assign o_lane_mode_select = st_reg.link_mode_select;
    assign o_lane_clk_en = st_reg.clk_en;
    assign o_ser_en = st_reg.ser_en;
    assign o_lane_pattern = st_reg.pat;
    assign o_cal_offset_setting = st_reg.cal_ofs;
    assign o_foreground_cal = st_reg.cal_fg;
    assign o_link_up = st_reg.link_up;
    // Lock is meaningless while the PLL is held down
    assign o_pll_locked = st_reg.pll_en & i_pll_locked;

endmodule // cple_dev

`default_nettype wire

// *** core/cple_host.sv ***
// Controller end: takes power-down and extra lane orders from software
// over a plain port and applies them to the device in a safe sequence.
// Assumes the device answers reads one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none

module cple_host
    import cple_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_busy,
    cple_link_if.host bus
);
    import cple_pkg::*;

    cple_host_st_t st_reg;
    cple_host_st_t st_next;
    logic both_down;

    assign both_down = &st_reg.pdreq;

    always_comb begin
        st_next = st_reg;
        st_next.wr = 1'b0;
        st_next.rd = 1'b0;
        st_next.rdata = 8'h00;

        // ************************************************************
        // Software port; settings are frozen while a sequence runs
        // ************************************************************
        if (i_wr && st_reg.state == CPLE_S_IDLE) begin
            case (i_addr)
                CPLE_H_CTRL: st_next.ctrl = i_wdata;
                CPLE_H_PDREQ: st_next.pdreq = i_wdata[1:0];
                CPLE_H_EXTRA: st_next.extra = i_wdata;
                CPLE_H_GO: st_next.state = CPLE_S_DIS;
                default: begin
                end
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                CPLE_H_CTRL: st_next.rdata = st_reg.ctrl;
                CPLE_H_PDREQ: st_next.rdata = {6'h00, st_reg.pdreq};
                CPLE_H_EXTRA: st_next.rdata = st_reg.extra;
                CPLE_H_STATUS: st_next.rdata = st_reg.dev_status;
                default: begin
                end
            endcase
        end

        // ************************************************************
        // Apply sequence: one device access per cycle
        // ************************************************************
        case (st_reg.state)
            CPLE_S_IDLE: begin
            end
            CPLE_S_DIS: begin
                st_next.addr = CPLE_ADDR_LINKCTL;
                st_next.wdata = 8'h00;
                st_next.wr = 1'b1;
                st_next.state = CPLE_S_PD;
            end
            CPLE_S_PD: begin
                st_next.addr = CPLE_ADDR_PD;
                st_next.wdata = both_down ? 8'h00 : {6'h00, st_reg.pdreq};
                st_next.wr = 1'b1;
                st_next.state = CPLE_S_MODE;
            end
            CPLE_S_MODE: begin
                st_next.addr = CPLE_ADDR_OPMODE;
                st_next.wdata = 8'h00;
                st_next.wdata[CPLE_GPD_BIT] = both_down;
                st_next.wr = 1'b1;
                st_next.state = CPLE_S_EXTRA;
            end
            CPLE_S_EXTRA: begin
                st_next.addr = CPLE_ADDR_EXTRA;
                st_next.wdata = st_reg.extra;
                st_next.wr = 1'b1;
                st_next.state = CPLE_S_CAL;
            end
            CPLE_S_CAL: begin
                st_next.addr = CPLE_ADDR_CALCFG;
                st_next.wdata = 8'h00;
                st_next.wdata[CPLE_CAL_FG_BIT] = st_reg.ctrl[CPLE_HC_FG_BIT];
                st_next.wdata[CPLE_CAL_OFS_BIT] =
                    st_reg.ctrl[CPLE_HC_FG_BIT] & (|st_reg.pdreq);
                st_next.wr = 1'b1;
                st_next.state = CPLE_S_EN;
            end
            CPLE_S_EN: begin
                st_next.addr = CPLE_ADDR_LINKCTL;
                st_next.wdata = 8'h00;
                st_next.wdata[CPLE_LINK_EN_BIT] = st_reg.ctrl[CPLE_HC_LINK_BIT];
                st_next.wr = 1'b1;
                st_next.state = CPLE_S_RDST;
            end
            CPLE_S_RDST: begin
                st_next.addr = CPLE_ADDR_STATUS;
                st_next.rd = 1'b1;
                st_next.state = CPLE_S_CAPT;
            end
            CPLE_S_CAPT: begin
                // The strobe is still out here; the answer stands next cycle
                if (!st_reg.rd) begin
                    st_next.dev_status = bus.rdata;
                    st_next.state = CPLE_S_IDLE;
                end
            end
            default: begin
                st_next.state = CPLE_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= CPLE_HOST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rdata = st_reg.rdata;
    assign o_busy = (st_reg.state != CPLE_S_IDLE);
    assign bus.addr = st_reg.addr;
    assign bus.wdata = st_reg.wdata;
    assign bus.wr = st_reg.wr;
    assign bus.rd = st_reg.rd;

endmodule // cple_host

`default_nettype wire

// *** dv/cple_link_monitor.sv ***
// Checker on the controller-to-device register link.
// Assumes the shared clock and active-low reset of the bench.
`timescale 1ns/100ps
`default_nettype none

module cple_link_monitor
    import cple_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [11:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_rdata
);
    logic link_on_reg;
    logic pdw_reg;
    logic gpd_reg;

    // Shadows of what the controller last wrote, for sequence checks
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            link_on_reg <= 1'b0;
            pdw_reg <= 1'b0;
            gpd_reg <= 1'b0;
        end else if (i_wr) begin
            if (i_addr == CPLE_ADDR_LINKCTL) link_on_reg <= i_wdata[CPLE_LINK_EN_BIT];
            if (i_addr == CPLE_ADDR_PD) pdw_reg <= (i_wdata[1:0] != 2'b00);
            if (i_addr == CPLE_ADDR_OPMODE) gpd_reg <= i_wdata[CPLE_GPD_BIT];
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_pd_link_off: assert property (
        i_wr && i_addr == CPLE_ADDR_PD |-> !link_on_reg)
        else $error("power-down written while enabled");
    a_extra_link_off: assert property (
        i_wr && i_addr == CPLE_ADDR_EXTRA |-> !link_on_reg)
        else $error("extra lanes written while enabled");
    a_both_via_mode: assert property (
        i_wr && i_addr == CPLE_ADDR_PD |-> i_wdata[1:0] != 2'b11)
        else $error("both channels via power-down");
    a_mode_after_pd: assert property (
        i_wr && i_addr == CPLE_ADDR_PD |=> i_wr && i_addr == CPLE_ADDR_OPMODE)
        else $error("mode write missing");
    a_cal_offset_set: assert property (
        i_wr && i_addr == CPLE_ADDR_CALCFG |-> i_wdata[CPLE_CAL_OFS_BIT] ==
        (i_wdata[CPLE_CAL_FG_BIT] && (pdw_reg || gpd_reg)))
        else $error("calibration offset wrong");
    a_enable_comes_last: assert property (
        i_wr && i_addr == CPLE_ADDR_EXTRA |=> i_wr && i_addr == CPLE_ADDR_CALCFG
        ##1 i_wr && i_addr == CPLE_ADDR_LINKCTL)
        else $error("enable not last");
    a_status_reserved: assert property (
        i_rd && i_addr == CPLE_ADDR_STATUS |=> (i_rdata & 8'hBB) == 8'h00)
        else $error("status reserved set");
    a_pll_lost_both: assert property (
        i_rd && i_addr == CPLE_ADDR_STATUS && gpd_reg |=> !i_rdata[CPLE_ST_PLL_BIT])
        else $error("lock kept");
endmodule // cple_link_monitor

`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench: controller and device joined by the link interface.
// Assumes the core package, interface and both ends are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import cple_pkg::*;
    logic i_clk;
    logic i_rst_b;
    logic [3:0] sw_addr;
    logic [7:0] sw_wdata;
    logic sw_wr;
    logic sw_rd;
    logic [7:0] sw_rdata;
    logic busy;
    logic [4:0] mode_sel;
    logic [3:0] pat_sel;
    logic [7:0] lane_mask;
    logic [3:0] binding;
    logic pll_lock;
    logic link_sync;
    logic pda, pdb, pll_en, mf_en, tx_en, ofs, fg, up, lock;
    logic [3:0] dig_pd;
    logic [4:0] lmode;
    logic [7:0] clk_en, ser_en;
    cple_pat_t pat;
    logic [7:0] v;
    int failures = 0;
    int n_compared = 0;

    cple_link_if link();
    cple_host cple_host_inst(.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(sw_addr),
        .i_wdata(sw_wdata), .i_wr(sw_wr), .i_rd(sw_rd), .o_rdata(sw_rdata), .o_busy(busy),
        .bus(link));
    cple_dev cple_dev_inst(.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(link),
        .i_link_mode_select(mode_sel), .i_link_test_pattern_select(pat_sel),
        .i_mode_lane_mask(lane_mask), .i_digital_channel_binding(binding),
        .i_pll_locked(pll_lock), .i_link_sync(link_sync), .o_power_down_a_converter(pda),
        .o_power_down_b_converter(pdb), .o_dig_pd(dig_pd), .o_pll_en(pll_en),
        .o_mfclk_en(mf_en), .o_link_transmit_enable(tx_en), .o_lane_mode_select(lmode),
        .o_lane_clk_en(clk_en), .o_ser_en(ser_en), .o_lane_pattern(pat),
        .o_cal_offset_setting(ofs), .o_foreground_cal(fg), .o_link_up(up), .o_pll_locked(lock));
    cple_link_monitor cple_link_monitor_inst(.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_addr(link.addr), .i_wdata(link.wdata), .i_wr(link.wr), .i_rd(link.rd),
        .i_rdata(link.rdata));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge i_clk);
        sw_wr <= 1'b0;
    endtask

    task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge i_clk);
        sw_rd <= 1'b0;
        @(negedge i_clk);
        d = sw_rdata;
    endtask

    // Waits on the busy flag under a bound so a stuck sequence cannot hang
    task automatic wait_idle();
        int n;
        n = 0;
        @(negedge i_clk);
        chk8("busy", 8'h01, {7'h0, busy});
        while (busy !== 1'b0 && n < 50) begin
            @(negedge i_clk);
            n++;
        end
        chk8("idle", 8'h00, {7'h0, busy});
        repeat (2) @(negedge i_clk);
    endtask

    task automatic run(input logic [7:0] c, input logic [7:0] p, input logic [7:0] e);
        sw_write(CPLE_H_CTRL, c);
        sw_write(CPLE_H_PDREQ, p);
        sw_write(CPLE_H_EXTRA, e);
        sw_write(CPLE_H_GO, 8'h01);
        wait_idle();
    endtask

    task automatic t_reset();
        @(negedge i_clk);
        chk8("pd_out", 8'h00, {6'h0, pdb, pda});
        chk8("pll_en", 8'h03, {6'h0, mf_en, pll_en});
        sw_read(4'hF, v);
        chk8("unmapped", 8'h00, v);
    endtask

    task automatic t_single();
        for (int i = 0; i < 2; i++) begin
            run(8'h01, (i == 0) ? 8'h01 : 8'h02, 8'h00);
            chk8("pd_out", (i == 0) ? 8'h01 : 8'h02, {6'h0, pdb, pda});
            chk8("dig_pd", {4'h0, binding ^ {4{i == 0}}}, {4'h0, dig_pd});
            chk8("link_run", 8'h07, {5'h0, tx_en, mf_en, pll_en});
            chk8("lanes", lane_mask, clk_en);
            chk8("up_lock", 8'h03, {6'h0, up, lock});
            sw_read(CPLE_H_STATUS, v);
            chk8("status", 8'h04, v & 8'h04);
        end
    endtask

    task automatic t_both();
        run(8'h01, 8'h03, 8'h0F);
        chk8("pll_mf", 8'h00, {6'h0, mf_en, pll_en});
        chk8("clk_off", 8'h00, clk_en);
        chk8("ser_off", 8'h00, ser_en);
        chk8("lock", 8'h00, {7'h0, lock});
        sw_read(CPLE_H_STATUS, v);
        chk8("status", 8'h00, v & 8'h04);
    endtask

    task automatic t_extra();
        @(posedge i_clk);
        lane_mask <= 8'h01;
        pat_sel <= CPLE_PAT_NONE;
        run(8'h01, 8'h00, 8'h0F);
        chk8("clk_en", 8'h0F, clk_en);
        chk8("ser_en", 8'h0F, ser_en);
        chk8("pat1", {4'h0, CPLE_PAT_RAMP}, {4'h0, pat[1]});
        sw_read(CPLE_H_EXTRA, v);
        chk8("extra_rb", 8'h0F, v);
        run(8'h01, 8'h00, 8'h23);
        chk8("clk_en", 8'h23, clk_en);
        chk8("ser_gap", 8'h03, ser_en);
        @(posedge i_clk);
        pat_sel <= CPLE_PAT_ALT;
        run(8'h01, 8'h00, 8'h22);
        chk8("clk_only", 8'h23, clk_en);
        chk8("ser_mode", 8'h01, ser_en);
        chk8("pat5", {4'h0, CPLE_PAT_RAMP}, {4'h0, pat[5]});
        @(posedge i_clk);
        pat_sel <= 4'h3;
        repeat (3) @(negedge i_clk);
        chk8("pat5", 8'h03, {4'h0, pat[5]});
        chk8("pat0", 8'h03, {4'h0, pat[0]});
        chk8("mode", {3'h0, mode_sel}, {3'h0, lmode});
    endtask

    task automatic t_cal_and_drop();
        run(8'h03, 8'h01, 8'h00);
        chk8("cal", 8'h03, {6'h0, fg, ofs});
        sw_write(CPLE_H_PDREQ, 8'h00);
        sw_write(CPLE_H_CTRL, 8'h02);
        sw_write(CPLE_H_GO, 8'h01);
        // Written while busy, so it must be dropped
        sw_write(CPLE_H_PDREQ, 8'h02);
        wait_idle();
        chk8("cal", 8'h02, {6'h0, fg, ofs});
        sw_read(CPLE_H_PDREQ, v);
        chk8("drop", 8'h00, v);
        chk8("pd_out", 8'h00, {6'h0, pdb, pda});
    endtask

    initial begin
        #400000;
        failures++;
        report_and_stop();
    end

    initial begin
        i_rst_b = 1'b0;
        {sw_addr, sw_wdata, sw_wr, sw_rd, pat_sel} = '0;
        mode_sel = 5'h0A;
        lane_mask = 8'h03;
        binding = 4'b0110;
        pll_lock = 1'b1;
        link_sync = 1'b1;
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_single();
        t_both();
        t_extra();
        t_cal_and_drop();
        report_and_stop();
    end
endmodule // tb_top

`default_nettype wire
